// File: include/interval_timer_pkg.sv
// Shared constants and carriers for the three-channel interval counter/timer
package interval_timer_pkg;

    localparam int CNT_W = 32;
    localparam int NUM_CTR = 3;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 32'h0;
    localparam logic [CNT_W:0] PERIOD_EXTRA = 33'h2;
    localparam logic [CNT_W:0] STEP_ONE = 33'h1;

    localparam logic [2:0] MODE_TERM = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;

    // Per-counter software settings
    typedef struct packed {
        logic [2:0] mode;
        logic [CNT_W-1:0] reload_value;
        logic inv_gate;
        logic inv_clock;
        logic inv_out;
        logic gate_from_sw;
        logic sw_gate;
        logic ext_clock_sel;
        logic irq_en;
    } ctr_cfg_t;

    // Per-counter working state
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic out;
        logic wrap;
        logic run;
        logic gate_prev;
        logic clk_prev;
    } ctr_state_t;

    // Per-counter readback
    typedef struct packed {
        logic [CNT_W-1:0] latched_count;
        logic out_level;
        logic gate_level;
        logic running;
    } ctr_status_t;

endpackage

// File: src/interval_counter_timer.sv
// Three independent 32-bit down counters with six modes each
//
// Contract
// [R1] Three independent 32-bit pure binary down counters.
// [R2] Each counter takes its own mode, zero to five.
// [R3] Status readable; latch command freezes count for a consistent read.
// [R4] Gate, clock input and output polarity invertible by software.
// [R5] Gate from hardware pin or software bit; gate level readable.
// [R6] Per-counter interrupt enable; shared status shows which counter requested.
// [R7] Count clock is bus clock divided by four or the 10 MHz oscillator.
// [R8] Mode zero: output low while counting, high when count reaches zero.
// [R9] Mode zero: output stays high until a new count is written.
// [R10] Mode one: like mode zero but gate edge retriggers the count.
// [R11] Mode two: output high, low for one clock at count end.
// [R12] Mode two: reloads automatically forever, interrupt at each cycle end.
// [R13] Modes two and three: period is reload plus two clocks.
// [R14] Mode three: high first half, low for the rest, periodic.
// [R15] Mode four: count write starts; output low one clock at expiry.
// [R16] Mode four: count written while counting loads on next clock.
// [R17] Mode five: like mode four, gate edge triggers and retriggers.
// [R18] Expiry raises interrupt request when that counter is enabled.
// [R19] Each counter has its own gate input pin and output pin.
// [R20] Mode three odd reload: high phase one clock longer than low.
// [R21] Modes zero, two, three, four: inactive gate holds the count.
`timescale 1ns/1ps

// Use: set a counter's cfg first, then pulse its count_write bit.
// Modes 1 and 5 then wait for a rising gate edge before counting.
// Commands are one clk cycle pulses; settings are plain levels.
module interval_counter_timer
    import interval_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Count clock sources
    input wire logic clock_sel_osc,
    input wire logic osc_10mhz_in,
    input wire logic counter1_ext_clock_in,
    input wire logic counter2_ext_clock_in,
    // Field gate inputs
    input wire logic counter0_gate_in,
    input wire logic counter1_gate_in,
    input wire logic counter2_gate_in,
    // Software settings and commands
    input wire ctr_cfg_t cfg [NUM_CTR],
    input wire logic [NUM_CTR-1:0] count_write,
    input wire logic [NUM_CTR-1:0] latch_cmd,
    input wire logic [NUM_CTR-1:0] irq_clear,
    // Field outputs
    output logic counter0_output,
    output logic counter1_output,
    output logic counter2_output,
    // Readback and interrupt
    output ctr_status_t status [NUM_CTR],
    output logic [NUM_CTR-1:0] irq_status,
    output logic irq_req
);

    // Count clock prescaler and oscillator edge detect
    logic [1:0] div_q, div_d;
    logic osc_prev_q, osc_prev_d;
    logic counter0_internal_clock;

    // Counter state
    ctr_state_t st_q [NUM_CTR];
    ctr_state_t st_d [NUM_CTR];

    // Readback and interrupt next values
    ctr_status_t status_d [NUM_CTR];
    logic [NUM_CTR-1:0] irq_status_d;
    logic irq_req_d;

    // Pin drive after polarity
    logic [NUM_CTR-1:0] out_pin_q, out_pin_d;

    // Raw field levels, one bit per counter
    logic [NUM_CTR-1:0] gate_raw;
    logic [NUM_CTR-1:0] ext_clk_raw;

    assign gate_raw = {counter2_gate_in, counter1_gate_in, counter0_gate_in};  // [R19]
    // Counter 0 has no field clock pin; its field clock input is tied low
    assign ext_clk_raw = {counter2_ext_clock_in, counter1_ext_clock_in, 1'b0};

    // True while the square wave is in its high phase at the given position.
    // Remaining ticks r below floor(P/2) are low, so odd P gives the extra tick high.
    function automatic logic square_high(input logic [CNT_W-1:0] count,
                                         input logic wrap,
                                         input logic [CNT_W-1:0] reload);
        logic [CNT_W:0] remaining;
        logic [CNT_W:0] half;
        remaining = wrap ? {1'b0, COUNT_ZERO} : ({1'b0, count} + STEP_ONE);
        half = ({1'b0, reload} + PERIOD_EXTRA) >> 1;
        square_high = remaining >= half;  // [R14] [R20]
    endfunction

    // Base count tick: bus clock divided by four, or oscillator rising edge
    always_comb begin
        div_d = div_q + 2'h1;
        osc_prev_d = osc_10mhz_in;
        counter0_internal_clock = clock_sel_osc ? (osc_10mhz_in & ~osc_prev_q)
                                                : (div_q == DIV4_LAST);  // [R7]
    end

    // Prescaler free runs; a write does not resync it, so the
    // first tick after a write may come up to four clk cycles late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= 2'h0;
            osc_prev_q <= 1'b0;
        end else begin
            div_q <= div_d;
            osc_prev_q <= osc_prev_d;
        end
    end

    // Mode overview, in base ticks with reload R:
    //   0  out low after write, high at terminal count, stays high
    //   1  as 0, but only a rising gate edge starts it, reloading the count
    //   2  high for R+1 ticks, low for the one wrap tick, reload, repeat
    //   3  same R+2 period, split into a high and a low phase
    //   4  out high after write, low one tick at expiry, then stops
    //   5  as 4, but a rising gate edge loads and restarts it
    //
    // Hazards and limits:
    //   A write always wins over a trigger or tick in the same cycle.
    //   Gate edges are seen on consecutive clk samples, so a gate pulse
    //   shorter than one clk may be missed entirely.
    //   Field clocks must run well below half of clk; faster edges
    //   merge and are lost rather than counted twice.
    //   The wrap state costs one tick so the period is R+2, not R+1.
    //   Codes 6 and 7 freeze the counter but still honour writes.
    //   Interrupt events: modes 0 and 1 at terminal count, 2 and 3 at
    //   the wrap tick, 4 and 5 at the strobe tick.
    //   An interrupt bit set and cleared in one cycle stays set.
    //   Status fields lag the live state by one clk cycle.
    //   Inverting the output flips the pin only; the status level
    //   follows the uninverted state.

    // Per-counter next state
    always_comb begin
        logic gate;
        logic clk_lvl;
        logic tick;
        logic trig;
        logic event_hit;
        gate = 1'b0;
        clk_lvl = 1'b0;
        tick = 1'b0;
        trig = 1'b0;
        event_hit = 1'b0;
        irq_status_d = irq_status;

        // Each counter is independent; only the base tick and the interrupt request are shared
        for (int i = 0; i < NUM_CTR; i++) begin
            st_d[i] = st_q[i];
            status_d[i] = status[i];
            event_hit = 1'b0;
            gate = cfg[i].gate_from_sw ? cfg[i].sw_gate
                                       : (gate_raw[i] ^ cfg[i].inv_gate);  // [R5] [R4]
            clk_lvl = ext_clk_raw[i] ^ cfg[i].inv_clock;  // [R4]
            st_d[i].gate_prev = gate;
            st_d[i].clk_prev = clk_lvl;
            // Counters 1 and 2 may count field clock edges instead of the base tick
            tick = cfg[i].ext_clock_sel ? (clk_lvl & ~st_q[i].clk_prev)
                                        : counter0_internal_clock;
            // Rising edge of the effective gate, after inversion
            trig = gate & ~st_q[i].gate_prev;

            if (count_write[i]) begin
                // A write reloads every mode and starts all but modes one and five; in mode four this is the next-clock load
                st_d[i].count = cfg[i].reload_value;  // [R16]
                st_d[i].wrap = 1'b0;
                st_d[i].run = (cfg[i].mode != MODE_ONESHOT) && (cfg[i].mode != MODE_HW_STROBE);
                st_d[i].out = (cfg[i].mode != MODE_TERM) && (cfg[i].mode != MODE_ONESHOT);
            end else begin
                unique case (cfg[i].mode)
                    MODE_TERM, MODE_ONESHOT: begin
                        // Trigger reloads even mid-count, which makes it retriggerable
                        if (cfg[i].mode == MODE_ONESHOT && trig) begin
                            st_d[i].count = cfg[i].reload_value;  // [R10]
                            st_d[i].out = 1'b0;
                            st_d[i].run = 1'b1;
                        end else if (tick && st_q[i].run &&
                                     (gate || cfg[i].mode == MODE_ONESHOT)) begin  // [R21]
                            if (st_q[i].count == COUNT_ZERO) begin
                                st_d[i].out = 1'b1;  // [R8]
                                st_d[i].run = 1'b0;  // [R9]
                                event_hit = 1'b1;
                            end else begin
                                st_d[i].count = st_q[i].count - 32'h1;  // [R1]
                            end
                        end
                    end

                    // Periodic modes reload themselves after the wrap tick
                    MODE_RATE, MODE_SQUARE: begin
                        if (tick && st_q[i].run && gate) begin  // [R21]
                            if (st_q[i].wrap) begin
                                st_d[i].wrap = 1'b0;
                                st_d[i].count = cfg[i].reload_value;  // [R12]
                            end else if (st_q[i].count == COUNT_ZERO) begin
                                // Extra wrap tick makes the period reload plus two
                                st_d[i].wrap = 1'b1;  // [R13]
                                event_hit = 1'b1;  // [R12]
                            end else begin
                                st_d[i].count = st_q[i].count - 32'h1;
                            end
                            if (cfg[i].mode == MODE_RATE) begin
                                st_d[i].out = ~st_d[i].wrap;  // [R11]
                            end else begin
                                st_d[i].out = square_high(st_d[i].count, st_d[i].wrap,
                                                          cfg[i].reload_value);  // [R14]
                            end
                        end
                    end

                    // Strobe modes stop after their one low tick
                    MODE_SW_STROBE, MODE_HW_STROBE: begin
                        // Gate edge restarts the strobe sequence at any time
                        if (cfg[i].mode == MODE_HW_STROBE && trig) begin
                            st_d[i].count = cfg[i].reload_value;  // [R17]
                            st_d[i].out = 1'b1;
                            st_d[i].wrap = 1'b0;
                            st_d[i].run = 1'b1;
                        end else if (tick && st_q[i].wrap) begin
                            st_d[i].out = 1'b1;  // [R15]
                            st_d[i].wrap = 1'b0;
                        end else if (tick && st_q[i].run &&
                                     (gate || cfg[i].mode == MODE_HW_STROBE)) begin
                            if (st_q[i].count == COUNT_ZERO) begin
                                st_d[i].out = 1'b0;  // [R15]
                                st_d[i].wrap = 1'b1;
                                st_d[i].run = 1'b0;
                                event_hit = 1'b1;
                            end else begin
                                st_d[i].count = st_q[i].count - 32'h1;
                            end
                        end
                    end

                    default: begin
                        // Unused mode codes hold the counter still
                        st_d[i].run = st_q[i].run;
                    end
                endcase
            end

            // Latch freezes a copy; the live count keeps running
            if (latch_cmd[i]) begin
                status_d[i].latched_count = st_q[i].count;  // [R3]
            end
            status_d[i].out_level = st_q[i].out;  // [R3]
            status_d[i].gate_level = gate;  // [R5]
            status_d[i].running = st_q[i].run;

            out_pin_d[i] = st_d[i].out ^ cfg[i].inv_out;  // [R4]
            // Set wins over a clear arriving in the same cycle
            irq_status_d[i] = (irq_status[i] & ~irq_clear[i]) |
                              (event_hit & cfg[i].irq_en);  // [R6] [R18]
        end

        irq_req_d = |irq_status_d;  // [R18]
    end

    // Everything reads zero in reset, so pins are low in reset and idle at the inv_out level until loaded
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                st_q[i] <= '0;
                status[i] <= '0;
            end
            out_pin_q <= '0;
            irq_status <= '0;
            irq_req <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CTR; i++) begin
                st_q[i] <= st_d[i];
                status[i] <= status_d[i];
            end
            out_pin_q <= out_pin_d;
            irq_status <= irq_status_d;
            irq_req <= irq_req_d;
        end
    end

    // Output pins come straight from their flops
    // Plain wiring only, so no logic sits between flop and pin
    always_comb begin
        counter0_output = out_pin_q[0];
        counter1_output = out_pin_q[1];
        counter2_output = out_pin_q[2];
    end

endmodule // interval_counter_timer

// File: verification/field_side_model.sv
// Field side: oscillator and external count clocks
`timescale 1ns/1ps
module field_side_model (
    // Bench control
    input wire logic ext_run,
    // Clock sources
    output logic osc_10mhz_in,
    output logic counter1_ext_clock_in,
    output logic counter2_ext_clock_in
);
    // Offsets keep every source edge off the clk edges, so no race in sampling
    initial begin
        osc_10mhz_in = 1'b0;
        #5;
        forever #50 osc_10mhz_in = !osc_10mhz_in;
    end
    // Field clock stands low between bursts, unrelated to clk
    initial begin
        counter1_ext_clock_in = 1'b0;
        #3;
        forever #70 counter1_ext_clock_in = ext_run ? !counter1_ext_clock_in : 1'b0;
    end
    assign counter2_ext_clock_in = counter1_ext_clock_in;
endmodule // field_side_model

// File: verification/interval_counter_timer_properties.sv
// Port checker for the interval counter/timer
`timescale 1ns/1ps
module interval_counter_timer_properties
    import interval_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed ports
    input wire logic clock_sel_osc,
    input wire ctr_cfg_t cfg [NUM_CTR],
    input wire logic [NUM_CTR-1:0] count_write,
    input wire logic [NUM_CTR-1:0] latch_cmd,
    input wire logic counter0_output,
    input wire logic counter1_output,
    input wire logic counter2_output,
    input wire ctr_status_t status [NUM_CTR],
    input wire logic [NUM_CTR-1:0] irq_status,
    input wire logic irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic lvl_q, lvl_d, chg, sq_on, rate_on;
    logic [1:0] seen_q, seen_d;
    logic [15:0] run_q, run_d;
    logic [CNT_W:0] per, lo_len, hi_len;
    assign chg = counter2_output != lvl_q;
    assign sq_on = cfg[2].mode == MODE_SQUARE && !clock_sel_osc && !cfg[2].ext_clock_sel;
    assign rate_on = cfg[1].mode == MODE_RATE && !clock_sel_osc && !cfg[1].ext_clock_sel;
    assign per = {1'b0, cfg[2].reload_value} + PERIOD_EXTRA;
    assign lo_len = (per >> 1) << 2;
    assign hi_len = (per - (per >> 1)) << 2;
    // First phase after a write is partial, so skip two changes
    always_comb begin
        lvl_d = counter2_output;
        run_d = chg ? 16'h1 : run_q + 16'h1;
        seen_d = seen_q;
        if (count_write[2] || !sq_on)
            seen_d = 2'h0;
        else if (chg && seen_q != 2'h2)
            seen_d = seen_q + 2'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 1'b0;
            run_q <= 16'h0;
            seen_q <= 2'h0;
        end else begin
            lvl_q <= lvl_d;
            run_q <= run_d;
            seen_q <= seen_d;
        end
    end
    sequence s_low_tick;
        !counter1_output [*4];
    endsequence
    sequence s_back_high;
        counter1_output;
    endsequence
    AST_IRQ_SET: assert property (|irq_status |-> ##[0:1] irq_req)
        else $error("irq_req missing");
    AST_IRQ_EN: assert property ($rose(irq_status[1]) |-> $past(cfg[1].irq_en))
        else $error("irq set while disabled");
    AST_M0_LOW: assert property (count_write[0] && cfg[0].mode == MODE_TERM
        && !cfg[0].inv_out && cfg[0].reload_value != COUNT_ZERO |=> !counter0_output [*4])
        else $error("mode 0 output not low");
    AST_M0_HOLD: assert property (cfg[0].mode == MODE_TERM && !cfg[0].inv_out
        && counter0_output && !count_write[0] |=> counter0_output)
        else $error("mode 0 output dropped");
    AST_RATE_PULSE: assert property (rate_on && $fell(counter1_output)
        |-> s_low_tick ##1 s_back_high)
        else $error("rate pulse width wrong");
    AST_SQ_HIGH: assert property (chg && !counter2_output && seen_q == 2'h2 && sq_on
        |-> {17'h0, run_q} == hi_len)
        else $error("square high phase wrong");
    AST_SQ_LOW: assert property (chg && counter2_output && seen_q == 2'h2 && sq_on
        |-> {17'h0, run_q} == lo_len)
        else $error("square low phase wrong");
    AST_LATCH_HOLD: assert property (!latch_cmd[0] ##1 !latch_cmd[0]
        |=> $stable(status[0].latched_count))
        else $error("latched count moved");
    AST_GATE: assert property ((cfg[0].gate_from_sw && !cfg[0].sw_gate
        && !cfg[0].inv_gate) [*2] |-> !status[0].gate_level)
        else $error("gate level wrong");
endmodule // interval_counter_timer_properties

bind interval_counter_timer interval_counter_timer_properties interval_counter_timer_properties_i (
    .clk(clk), .rst(rst), .clock_sel_osc(clock_sel_osc), .cfg(cfg),
    .count_write(count_write), .latch_cmd(latch_cmd), .counter0_output(counter0_output),
    .counter1_output(counter1_output), .counter2_output(counter2_output),
    .status(status), .irq_status(irq_status), .irq_req(irq_req));

// File: verification/interval_counter_timer_tb_top.sv
// Self-checking bench for the interval counter/timer
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        tests_run++; \
        if ((a) !== (e)) begin \
            bad_count++; \
            $display("BAD %0t %0h %0h", $time, (a), (e)); \
        end \
    end
module interval_counter_timer_tb_top;
    import interval_timer_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc_sel = 1'b1;
    logic ext_run = 1'b0;
    logic osc, ext1, ext2, irq_req;
    logic [2:0] gate = 3'h0;
    logic [2:0] wr = 3'h0;
    logic [2:0] lat = 3'h0;
    logic [2:0] clr = 3'h0;
    logic [2:0] outs, irq_status;
    ctr_cfg_t cfg [NUM_CTR];
    ctr_status_t status [NUM_CTR];
    int bad_count = 0;
    int tests_run = 0;
    int n;
    always #10 clk = !clk;
    field_side_model field_side_model_i (.ext_run(ext_run), .osc_10mhz_in(osc),
        .counter1_ext_clock_in(ext1), .counter2_ext_clock_in(ext2));
    interval_counter_timer interval_counter_timer_i (.clk(clk), .rst(rst),
        .clock_sel_osc(osc_sel), .osc_10mhz_in(osc), .counter1_ext_clock_in(ext1),
        .counter2_ext_clock_in(ext2), .counter0_gate_in(gate[0]), .counter1_gate_in(gate[1]),
        .counter2_gate_in(gate[2]), .cfg(cfg), .count_write(wr), .latch_cmd(lat),
        .irq_clear(clr), .counter0_output(outs[0]), .counter1_output(outs[1]),
        .counter2_output(outs[2]), .status(status), .irq_status(irq_status), .irq_req(irq_req));
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_lvl(input int i, input logic lvl, output int k);
        k = 0;
        while (outs[i] !== lvl) begin
            @(negedge clk);
            k++;
            if (k > 300) begin
                bad_count++;
                close_out();
            end
        end
    endtask
    task automatic load(input int i, input logic [2:0] m, input logic [31:0] r,
                        input logic hw, input logic io);
        @(negedge clk);
        cfg[i].mode = m;
        cfg[i].reload_value = r;
        cfg[i].gate_from_sw = !hw;
        cfg[i].inv_out = io;
        wr[i] = 1'b1;
        @(negedge clk);
        wr[i] = 1'b0;
    endtask
    task automatic t_osc_term();
        load(0, MODE_TERM, 32'h2, 1'b0, 1'b0);
        `CHK(outs[0], 1'b0)
        wait_lvl(0, 1'b1, n);
        `CHK(irq_status[0], 1'b1)
        `CHK(irq_req, 1'b1)
        repeat (30) @(negedge clk);
        `CHK(outs[0], 1'b1)
        clr[0] = 1'b1;
        @(negedge clk);
        clr[0] = 1'b0;
        `CHK(irq_status[0], 1'b0)
        osc_sel = 1'b0;
    endtask
    task automatic latch0();
        lat[0] = 1'b1;
        @(negedge clk);
        lat[0] = 1'b0;
        @(negedge clk);
    endtask
    task automatic t_gate_hold();
        cfg[0].sw_gate = 1'b0;
        load(0, MODE_TERM, 32'h28, 1'b0, 1'b0);
        repeat (20) @(negedge clk);
        latch0();
        `CHK(status[0].latched_count, 32'h28)
        `CHK(status[0].gate_level, 1'b0)
        `CHK(status[0].running, 1'b1)
        `CHK(status[0].out_level, 1'b0)
        cfg[0].sw_gate = 1'b1;
        repeat (20) @(negedge clk);
        latch0();
        `CHK(status[0].latched_count < 32'h28, 1'b1)
    endtask
    task automatic t_trigger();
        load(0, MODE_ONESHOT, 32'h2, 1'b1, 1'b0);
        repeat (30) @(negedge clk);
        `CHK(outs[0], 1'b0)
        gate[0] = 1'b1;
        wait_lvl(0, 1'b1, n);
        load(0, MODE_HW_STROBE, 32'h2, 1'b1, 1'b1);
        `CHK(outs[0], 1'b0)
        gate[0] = 1'b0;
        @(negedge clk);
        gate[0] = 1'b1;
        wait_lvl(0, 1'b1, n);
        wait_lvl(0, 1'b0, n);
        `CHK(n, 4)
    endtask
    task automatic t_strobe();
        load(0, MODE_SW_STROBE, 32'hC8, 1'b0, 1'b0);
        repeat (20) @(negedge clk);
        load(0, MODE_SW_STROBE, 32'h3, 1'b0, 1'b0);
        wait_lvl(0, 1'b0, n);
        `CHK(n < 40, 1'b1)
        wait_lvl(0, 1'b1, n);
        `CHK(n, 4)
        repeat (40) @(negedge clk);
        `CHK(outs[0], 1'b1)
    endtask
    task automatic t_periodic();
        load(1, MODE_RATE, 32'h3, 1'b0, 1'b0);
        load(2, MODE_SQUARE, 32'h5, 1'b0, 1'b0);
        wait_lvl(1, 1'b0, n);
        wait_lvl(1, 1'b1, n);
        `CHK(n, 4)
        wait_lvl(1, 1'b0, n);
        `CHK(n, 16)
        `CHK(irq_status[1], 1'b1)
        wait_lvl(2, 1'b0, n);
        wait_lvl(2, 1'b1, n);
        `CHK(n, 12)
        wait_lvl(2, 1'b0, n);
        `CHK(n, 16)
        `CHK(irq_status[2], 1'b0)
    endtask
    task automatic t_ext();
        wait_lvl(1, 1'b1, n);
        cfg[1].ext_clock_sel = 1'b1;
        load(1, MODE_TERM, 32'h3, 1'b0, 1'b0);
        repeat (40) @(negedge clk);
        `CHK(outs[1], 1'b0)
        ext_run = 1'b1;
        wait_lvl(1, 1'b1, n);
        `CHK(n < 40, 1'b1)
        ext_run = 1'b0;
    endtask
    initial begin
        for (int i = 0; i < NUM_CTR; i++) begin
            cfg[i] = '0;
            cfg[i].gate_from_sw = 1'b1;
            cfg[i].sw_gate = 1'b1;
            cfg[i].irq_en = (i != 2);
        end
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_osc_term();
        t_gate_hold();
        t_trigger();
        t_strobe();
        t_periodic();
        t_ext();
        close_out();
    end
endmodule // interval_counter_timer_tb_top
